// ==== hdl/sfe_core.sv ====
// Serial front end of a 256-byte nonvolatile memory with a four-wire link and a pause pin.
// Assumes the host keeps select high for at least five core clocks between frames.
// Operation
// - Command byte held in eight-bit instruction register.
// - Input sampled on serial clock rising edges.
// - All bytes move most significant bit first.
// - Pause freezes device against clock and data.
// - Pause release resumes at same bit.
// - Self-timed write starts at select rise.
// - Array of 256 bytes, byte addressed.
// - Upper nibble zero, bit three ignored decoding.
// - Read pointer advances and wraps to zero.
// - Latch set only at select rise.
// - Write wraps within one sixteen-byte page.
`timescale 1ns/10ps
module sfe_core #(
  parameter int WRITE_CYCLES = sfe_pkg::WRITE_CYCLES,
  parameter int FIFO_DEPTH = sfe_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic sel_n,
  input wire logic ser_in,
  input wire logic pause_n,
  output logic ser_out,
  output logic ser_out_oe,
  output logic write_busy
);

  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);

  // ******************************************************************
  // State of the link domain
  // ******************************************************************
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [1:0] nbyte;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] ptr;
    logic [7:0] out_byte;
    logic out_en;
    logic ev_tog;
    logic [1:0] ev_kind;
    logic [7:0] ev_data;
    logic aligned;
    logic [3:0] st_s1;
    logic [3:0] st_s2;
    logic [3:0] st_s3;
    logic [3:0] st_q;
  } sfe_link_t;

  // ******************************************************************
  // State of the core domain
  // ******************************************************************
  typedef struct packed {
    logic [2:0] cs_s;
    logic cs_q;
    logic [2:0] tg_s;
    logic tg_q;
    logic [2:0] al_s;
    logic al_q;
    logic [7:0] fr_cmd;
    logic [7:0] fr_addr;
    logic [4:0] fr_nbyte;
    logic fr_bad;
    logic pend;
    logic [3:0] pidx;
    logic [3:0] page;
    logic [15:0] pvalid;
    logic busy;
    logic wel;
    logic [1:0] bp;
    logic [TMR_W-1:0] tmr;
  } sfe_core_t;

  sfe_link_t lk_r;
  sfe_link_t lk_nxt;
  sfe_core_t cr_r;
  sfe_core_t cr_nxt;
  logic fresh_r;
  logic ser_out_r;
  logic [7:0] mem [sfe_pkg::MEM_WORDS];
  logic [7:0] pbuf [sfe_pkg::PAGE_BYTES];
  logic [3:0] stat_mc;
  logic commit;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic pop;

  assign stat_mc = {cr_r.bp, cr_r.wel, cr_r.busy};
  assign write_busy = cr_r.busy;

  // ******************************************************************
  // Frame start marker
  // ******************************************************************
  // Set while select is high, cleared by the first unpaused clock edge of a frame.
  always_ff @(posedge ser_clk or posedge sel_n or posedge sys_rst)
  begin
    if (sys_rst)
      fresh_r <= 1'b1;
    else if (sel_n)
      fresh_r <= 1'b1;
    else if (pause_n)
      fresh_r <= 1'b0;
  end

  // ******************************************************************
  // Link shifter on the serial clock
  // ******************************************************************
  // The array is read straight from this domain; it only changes at the start of a self-timed write, and reads are not blocked while one runs.
  always_comb
  begin
    logic [2:0] bc;
    logic [1:0] nb;
    logic [7:0] sh;
    sfe_pkg::sfe_op_t op;
    logic [7:0] ra;
    bc = '0;
    ra = '0;
    nb = '0;
    sh = '0;
    op = sfe_pkg::SFE_OP_NONE;
    lk_nxt = lk_r;
    lk_nxt.st_s1 = stat_mc;
    lk_nxt.st_s2 = lk_r.st_s1;
    lk_nxt.st_s3 = lk_r.st_s2;
    if (lk_r.st_s2 == lk_r.st_s3)
      lk_nxt.st_q = lk_r.st_s3;
    if (pause_n)
    begin
      bc = fresh_r ? 3'h0 : lk_r.bit_cnt;
      nb = fresh_r ? sfe_pkg::KIND_CMD : lk_r.nbyte;
      sh = {lk_r.shreg[6:0], ser_in};
      lk_nxt.bit_cnt = 3'(bc + 3'h1);
      lk_nxt.shreg = sh;
      lk_nxt.nbyte = nb;
      lk_nxt.aligned = (bc == 3'h7);
      if (fresh_r)
        lk_nxt.out_en = 1'b0;
      if (bc == 3'h7)
      begin
        lk_nxt.ev_tog = ~lk_r.ev_tog;
        lk_nxt.ev_data = sh;
        lk_nxt.ev_kind = nb;
        if (nb != sfe_pkg::KIND_DATA)
          lk_nxt.nbyte = 2'(nb + 2'h1);
        op = sfe_pkg::sfe_decode((nb == sfe_pkg::KIND_CMD) ? sh : lk_r.cmd);
        if (nb == sfe_pkg::KIND_CMD)
        begin
          lk_nxt.cmd = sh;
          if (op == sfe_pkg::SFE_OP_READ_STATUS_CMD)
          begin
            lk_nxt.out_byte = {4'h0, lk_r.st_q};
            lk_nxt.out_en = 1'b1;
          end
        end
        else if (op == sfe_pkg::SFE_OP_READ)
        begin
          ra = (nb == sfe_pkg::KIND_ADDR) ? sh : lk_r.ptr;
          lk_nxt.out_byte = mem[ra];
          lk_nxt.ptr = 8'(ra + 8'h01);
          lk_nxt.out_en = 1'b1;
        end
        else if (op == sfe_pkg::SFE_OP_READ_STATUS_CMD)
          lk_nxt.out_byte = {4'h0, lk_r.st_q};
      end
    end
  end

  always_ff @(posedge ser_clk or posedge sys_rst)
  begin
    if (sys_rst)
      lk_r <= '0;
    else
      lk_r <= lk_nxt;
  end

  // Output bits change on the falling edge so the host samples them on the next rise.
  always_ff @(negedge ser_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ser_out_r <= 1'b0;
    else if (pause_n)
      ser_out_r <= lk_r.out_byte[3'h7 - lk_r.bit_cnt];
  end

  assign ser_out = ser_out_r;
  // The enable follows the pins directly so a pause or deselect releases the line at once.
  assign ser_out_oe = lk_r.out_en & ~fresh_r & ~sel_n & pause_n;

  // ******************************************************************
  // Core control on the system clock
  // ******************************************************************
  always_comb
  begin
    logic cs_rise;
    logic ev;
    sfe_pkg::sfe_op_t op;
    cr_nxt = cr_r;
    commit = 1'b0;
    push = 1'b0;
    cs_rise = 1'b0;
    ev = 1'b0;
    op = sfe_pkg::sfe_decode(cr_r.fr_cmd);
    cr_nxt.cs_s = {cr_r.cs_s[1:0], sel_n};
    cr_nxt.tg_s = {cr_r.tg_s[1:0], lk_r.ev_tog};
    cr_nxt.al_s = {cr_r.al_s[1:0], lk_r.aligned};
    if (cr_r.cs_s[1] == cr_r.cs_s[2])
    begin
      cr_nxt.cs_q = cr_r.cs_s[2];
      cs_rise = cr_r.cs_s[2] & ~cr_r.cs_q;
    end
    if (cr_r.tg_s[1] == cr_r.tg_s[2])
    begin
      cr_nxt.tg_q = cr_r.tg_s[2];
      ev = cr_r.tg_s[2] ^ cr_r.tg_q;
    end
    if (cr_r.al_s[1] == cr_r.al_s[2])
      cr_nxt.al_q = cr_r.al_s[2];

    // Bytes reported by the link.
    if (ev)
    begin
      if (lk_r.ev_kind == sfe_pkg::KIND_CMD)
      begin
        cr_nxt.fr_cmd = lk_r.ev_data;
        cr_nxt.fr_nbyte = 5'h01;
        // A command taken while a write is running has no effect at frame end; reads still return data from the link.
        cr_nxt.fr_bad = cr_r.busy;
      end
      else
      begin
        if (cr_r.fr_nbyte != sfe_pkg::NBYTE_SAT)
          cr_nxt.fr_nbyte = 5'(cr_r.fr_nbyte + 5'h01);
        if (lk_r.ev_kind == sfe_pkg::KIND_ADDR)
        begin
          cr_nxt.fr_addr = lk_r.ev_data;
          if (op == sfe_pkg::SFE_OP_WRITE)
          begin
            cr_nxt.pidx = lk_r.ev_data[3:0];
            cr_nxt.page = lk_r.ev_data[7:4];
            cr_nxt.pvalid = '0;
          end
        end
        else if (op == sfe_pkg::SFE_OP_WRITE)
        begin
          push = 1'b1;
          // A byte that finds the buffer full spoils the whole page.
          if (!fifo_in_ready)
            cr_nxt.fr_bad = 1'b1;
        end
      end
    end

    // Buffered data bytes land in the page buffer.
    if (pop)
    begin
      cr_nxt.pvalid[cr_r.pidx] = 1'b1;
      cr_nxt.pidx = 4'(cr_r.pidx + 4'h1);
    end

    if (cs_rise)
      cr_nxt.pend = 1'b1;

    // End of frame, judged once the buffer has drained.
    if (cr_r.pend && !fifo_out_valid)
    begin
      cr_nxt.pend = 1'b0;
      cr_nxt.fr_nbyte = '0;
      if (cr_r.al_q && !cr_r.fr_bad && !cr_r.busy)
      begin
        case (op)
          sfe_pkg::SFE_OP_SET_WRITE_LATCH_CMD:
            if (cr_r.fr_nbyte == 5'h01)
              cr_nxt.wel = 1'b1;
          sfe_pkg::SFE_OP_CLEAR_WRITE_LATCH_CMD:
            if (cr_r.fr_nbyte == 5'h01)
              cr_nxt.wel = 1'b0;
          sfe_pkg::SFE_OP_WRITE_STATUS_CMD:
            if (cr_r.fr_nbyte == 5'h02 && cr_r.wel)
            begin
              cr_nxt.bp = cr_r.fr_addr[sfe_pkg::ST_BP_HI:sfe_pkg::ST_BP_LO];
              cr_nxt.wel = 1'b0;
            end
          sfe_pkg::SFE_OP_WRITE:
            if (cr_r.fr_nbyte >= 5'h03 && cr_r.wel)
            begin
              commit = 1'b1;
              cr_nxt.busy = 1'b1;
              cr_nxt.tmr = TMR_W'(WRITE_CYCLES - 1);
            end
          default: cr_nxt.pend = 1'b0;
        endcase
      end
    end

    // Self-timed write: the array is updated at the start, busy stands for the full time.
    if (cr_r.busy)
    begin
      if (cr_r.tmr == '0)
      begin
        cr_nxt.busy = 1'b0;
        cr_nxt.wel = 1'b0;
      end
      else
        cr_nxt.tmr = TMR_W'(cr_r.tmr - 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cr_r <= '0;
      cr_r.cs_s <= sfe_pkg::SYNC_HIGH_RST;
      cr_r.cs_q <= 1'b1;
      cr_r.bp <= sfe_pkg::BP_RST;
    end
    else
      cr_r <= cr_nxt;
  end

  // ******************************************************************
  // Page buffer and array
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (pop)
      pbuf[cr_r.pidx] <= fifo_out_data;
  end

  always_ff @(posedge mclk)
  begin
    if (commit)
    begin
      for (int i = 0; i < sfe_pkg::PAGE_BYTES; i++)
      begin
        if (cr_r.pvalid[i] && !sfe_pkg::sfe_protected(cr_r.bp, {cr_r.page, 4'(i)}))
          mem[{cr_r.page, 4'(i)}] <= pbuf[i];
      end
    end
  end

  // The buffer drains only while no write runs; a frame sent meanwhile waits in it and is refused, as it began during the write.
  assign fifo_out_ready = ~cr_r.busy;
  assign pop = fifo_out_valid & fifo_out_ready;

  sfe_fifo #(
    .WIDTH(sfe_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(lk_r.ev_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

endmodule // sfe_core

// ==== hdl/sfe_pkg.sv ====
// Shared constants, types and the command decoder of the serial memory front end.
// Assumes a 25 MHz core clock and a host that drives the four-wire link plus the pause pin.
package sfe_pkg;

  // ******************************************************************
  // Geometry and timing
  // ******************************************************************
  localparam int BYTE_W = 8;
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int MCLK_HZ = 25_000_000;
  localparam int WRITE_TIME_MS = 5;
  // Longest time, so the count rounds down.
  localparam int WRITE_CYCLES = WRITE_TIME_MS * (MCLK_HZ / 1000);

  // ******************************************************************
  // Command byte layout and codes
  // ******************************************************************
  localparam logic [3:0] CMD_HI_ZERO = 4'h0;
  localparam logic [2:0] CODE_READ = 3'h3;
  localparam logic [2:0] CODE_WRITE = 3'h2;
  localparam logic [2:0] CODE_CLEAR_LATCH = 3'h4;
  localparam logic [2:0] CODE_SET_LATCH = 3'h6;
  localparam logic [2:0] CODE_READ_STATUS = 3'h5;
  localparam logic [2:0] CODE_WRITE_STATUS = 3'h1;

  // Byte kinds carried from the link to the core.
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;

  // Status byte fields.
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;

  // Protected regions for the block protection bits.
  localparam logic [7:0] PROT_QTR_BASE = 8'hc0;
  localparam logic [7:0] PROT_HALF_BASE = 8'h80;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;

  // Reset values and the saturation limit of the frame byte count.
  localparam logic [2:0] SYNC_HIGH_RST = 3'h7;
  localparam logic [2:0] SYNC_LOW_RST = 3'h0;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic [4:0] NBYTE_SAT = 5'h1f;

  typedef enum logic [2:0] {
    SFE_OP_NONE,
    SFE_OP_READ,
    SFE_OP_WRITE,
    SFE_OP_CLEAR_WRITE_LATCH_CMD,
    SFE_OP_SET_WRITE_LATCH_CMD,
    SFE_OP_READ_STATUS_CMD,
    SFE_OP_WRITE_STATUS_CMD
  } sfe_op_t;

  // Upper nibble must be zero, bit 3 is a don't care.
  function automatic sfe_op_t sfe_decode(input logic [7:0] b);
    sfe_op_t op;
    op = SFE_OP_NONE;
    if (b[7:4] == CMD_HI_ZERO)
    begin
      case (b[2:0])
        CODE_READ: op = SFE_OP_READ;
        CODE_WRITE: op = SFE_OP_WRITE;
        CODE_CLEAR_LATCH: op = SFE_OP_CLEAR_WRITE_LATCH_CMD;
        CODE_SET_LATCH: op = SFE_OP_SET_WRITE_LATCH_CMD;
        CODE_READ_STATUS: op = SFE_OP_READ_STATUS_CMD;
        CODE_WRITE_STATUS: op = SFE_OP_WRITE_STATUS_CMD;
        default: op = SFE_OP_NONE;
      endcase
    end
    return op;
  endfunction

  // True when the block protection bits forbid writing this address.
  function automatic logic sfe_protected(input logic [1:0] bp, input logic [7:0] a);
    logic p;
    p = 1'b1;
    if (bp == BP_NONE)
      p = 1'b0;
    else if (bp == BP_QTR)
      p = (a >= PROT_QTR_BASE);
    else if (bp == BP_HALF)
      p = (a >= PROT_HALF_BASE);
    return p;
  endfunction

endpackage

// ==== hdl/sfe_fifo.sv ====
// Synchronous first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/10ps
module sfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } sfe_fifo_st_t;

  sfe_fifo_st_t st_r;
  sfe_fifo_st_t st_nxt;
  logic [WIDTH-1:0] store [DEPTH];
  logic do_push;
  logic do_pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    logic [PW-1:0] n;
    n = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    return n;
  endfunction

  assign in_ready = (st_r.count != CW'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data = store[st_r.rd_ptr];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (do_push)
      st_nxt.wr_ptr = ptr_inc(st_r.wr_ptr);
    if (do_pop)
      st_nxt.rd_ptr = ptr_inc(st_r.rd_ptr);
    if (do_push && !do_pop)
      st_nxt.count = CW'(st_r.count + 1'b1);
    else if (do_pop && !do_push)
      st_nxt.count = CW'(st_r.count - 1'b1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
      store[st_r.wr_ptr] <= in_data;
  end

endmodule // sfe_fifo

// ==== verif/sfe_core_assertions.sv ====
// Concurrent checks on the ports of the serial memory front end.
// Assumes the host keeps the link clock low outside frames.
`timescale 1ns/10ps
module sfe_core_assertions #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic sel_n,
  input wire logic ser_in,
  input wire logic pause_n,
  input wire logic ser_out,
  input wire logic ser_out_oe,
  input wire logic write_busy
);
  // ******************************************************************
  // Helper counters
  // ******************************************************************
  int busy_cnt_r;
  logic [4:0] rise_cnt_r;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= write_busy ? busy_cnt_r + 1 : 0;

  // Rising link edges taken since select fell; pause edges are not counted.
  always_ff @(posedge ser_clk or posedge sel_n or posedge sys_rst)
    if (sel_n || sys_rst)
      rise_cnt_r <= 5'h00;
    else if (pause_n && rise_cnt_r != 5'h1f)
      rise_cnt_r <= rise_cnt_r + 5'h01;

  // ******************************************************************
  // Properties
  // ******************************************************************
  sequence s_oe_on;
    ser_out_oe ##1 (!sel_n && pause_n);
  endsequence

  property p_busy_after_sel;
    @(posedge mclk) disable iff (sys_rst) $rose(write_busy) |-> $past(sel_n, 2) && sel_n;
  endproperty

  property p_busy_length;
    @(posedge mclk) disable iff (sys_rst)
      $fell(write_busy) |-> busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1;
  endproperty

  // The enable comes up with the clock rise that ends a byte, or when a pause lets go in the low phase.
  property p_oe_on_byte;
    @(posedge mclk) disable iff (sys_rst) $rose(ser_out_oe) |-> !ser_clk || rise_cnt_r[2:0] == 3'h0;
  endproperty

  a_oe_sel_off: assert property (@(posedge mclk) disable iff (sys_rst) sel_n |-> !ser_out_oe)
    else $error("output enabled while deselected");
  a_oe_pause_off: assert property (@(posedge mclk) disable iff (sys_rst) !pause_n |-> !ser_out_oe)
    else $error("output enabled while paused");
  a_oe_on_byte: assert property (p_oe_on_byte)
    else $error("output enabled inside a byte");
  a_oe_stays_on: assert property (@(posedge mclk) disable iff (sys_rst) s_oe_on |-> ser_out_oe)
    else $error("output dropped inside a read");
  a_oe_after_cmd: assert property (@(posedge ser_clk) disable iff (sys_rst) ser_out_oe |-> rise_cnt_r >= 5'h08)
    else $error("output enabled before a full command byte");
  a_pause_hold_out: assert property (@(negedge ser_clk) disable iff (sys_rst) !pause_n |=> $stable(ser_out))
    else $error("output bit moved during pause");
  a_busy_after_sel: assert property (p_busy_after_sel)
    else $error("write started while selected");
  a_busy_length: assert property (p_busy_length)
    else $error("write time off");
endmodule // sfe_core_assertions

// ==== verif/sfe_host_model.sv ====
// Host side of the four-wire link: makes the serial clock, select, data and pause.
// Assumes callers run one frame at a time.
`timescale 1ns/10ps
module sfe_host_model (
  output logic ser_clk,
  output logic sel_n,
  output logic ser_in,
  output logic pause_n,
  input wire logic ser_out,
  input wire logic ser_out_oe
);
  localparam int HALF = 80;
  int pause_at = -1;
  int bit_no = 0;

  initial
  begin
    ser_clk = 1'b0;
    sel_n = 1'b1;
    ser_in = 1'b0;
    pause_n = 1'b1;
  end

  // The odd offset keeps link edges away from core clock edges.
  task automatic begin_frame();
    bit_no = 0;
    #7;
    sel_n = 1'b0;
    #HALF;
  endtask

  // The clock stays low between frames and data flips, so stale bits never look live.
  task automatic end_frame();
    #HALF;
    sel_n = 1'b1;
    ser_in = ~ser_in;
    #(5 * HALF);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (bit_no == pause_at)
      begin
        pause_n = 1'b0;
        repeat (3)
        begin
          ser_in = ~ser_in;
          #(HALF - 1);
          ser_clk = 1'b1;
          #HALF;
          ser_clk = 1'b0;
          #1;
        end
        pause_n = 1'b1;
        pause_at = -1;
      end
      ser_in = tx[i];
      #(HALF - 1);
      ser_clk = 1'b1;
      rx[i] = ser_out_oe ? ser_out : 1'bz;
      #HALF;
      ser_clk = 1'b0;
      #1;
      bit_no++;
    end
  endtask
endmodule // sfe_host_model

// ==== verif/testbench.sv ====
// Self-checking bench for the serial memory front end, driven through the host model.
// Assumes a shortened write time so a write lasts a few microseconds.
`timescale 1ns/10ps
module testbench;
  localparam int WCYC = 200;
  logic mclk;
  logic sys_rst;
  wire logic ser_clk, sel_n, ser_in, pause_n, ser_out, ser_out_oe, write_busy;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] rx[$];

  sfe_core #(.WRITE_CYCLES(WCYC), .FIFO_DEPTH(8)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .ser_clk(ser_clk),
    .sel_n(sel_n), .ser_in(ser_in), .pause_n(pause_n), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
    .write_busy(write_busy));
  sfe_host_model host_u (.ser_clk(ser_clk), .sel_n(sel_n), .ser_in(ser_in), .pause_n(pause_n),
    .ser_out(ser_out), .ser_out_oe(ser_out_oe));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] b;
    rx = {};
    host_u.begin_frame();
    foreach (tx[i])
    begin
      host_u.xfer(tx[i], b);
      rx.push_back(b);
    end
    host_u.end_frame();
  endtask

  task automatic status(input logic [7:0] exp);
    frame({8'h05, 8'h00});
    check("status", exp, rx[1]);
  endtask

  task automatic read_chk(input logic [7:0] c, input logic [7:0] a, input logic [7:0] exp[$]);
    frame({c, a, exp});
    foreach (exp[i])
      check("read data", exp[i], rx[i + 2]);
  endtask

  task automatic write_page(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d[$], input logic chk);
    int n;
    frame({8'h06});
    frame({c, a, d});
    if (chk)
      status(8'h03);
    n = 0;
    while (write_busy !== 1'b0 && n < 2 * WCYC)
    begin
      @(negedge mclk);
      n++;
    end
    check("write end", 8'h00, {7'h00, write_busy});
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic sc_latch();
    frame({8'h06, 8'h02, 8'h10, 8'h55});
    status(8'h00);
    frame({8'h06});
    status(8'h02);
    frame({8'h04});
    status(8'h00);
  endtask

  task automatic sc_page();
    write_page(8'h02, 8'h3e, {8'ha1, 8'ha2, 8'ha3}, 1'b1);
    status(8'h00);
    read_chk(8'h03, 8'h3e, {8'ha1, 8'ha2});
    read_chk(8'h0b, 8'h30, {8'ha3});
  endtask

  task automatic sc_wrap();
    write_page(8'h0a, 8'hff, {8'hc3}, 1'b1);
    write_page(8'h02, 8'h00, {8'h3c}, 1'b1);
    read_chk(8'h03, 8'hff, {8'hc3, 8'h3c});
  endtask

  task automatic sc_pause();
    host_u.pause_at = 20;
    read_chk(8'h03, 8'h3e, {8'ha1, 8'ha2});
    host_u.pause_at = 12;
    read_chk(8'h03, 8'hff, {8'hc3});
  endtask

  task automatic sc_bad_cmd();
    frame({8'h13, 8'h3e, 8'h00});
    check("ignored read", 8'hzz, rx[2]);
  endtask

  task automatic sc_protect();
    frame({8'h06});
    frame({8'h01, 8'h04});
    status(8'h04);
    write_page(8'h02, 8'hff, {8'h99}, 1'b0);
    read_chk(8'h03, 8'hff, {8'hc3});
    // Address 80 is still open with a quarter protected, then closed with half protected.
    write_page(8'h02, 8'h80, {8'h11}, 1'b0);
    frame({8'h06});
    frame({8'h01, 8'h08});
    status(8'h08);
    write_page(8'h02, 8'h80, {8'h22}, 1'b0);
    read_chk(8'h03, 8'h80, {8'h11});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    #2_000_000;
    errors++;
    results();
  end

  initial
  begin
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    sc_latch();
    sc_page();
    sc_wrap();
    sc_pause();
    sc_bad_cmd();
    sc_protect();
    results();
  end
endmodule // testbench

bind sfe_core sfe_core_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .ser_clk(ser_clk), .sel_n(sel_n), .ser_in(ser_in), .pause_n(pause_n), .ser_out(ser_out),
  .ser_out_oe(ser_out_oe), .write_busy(write_busy));
